// ==== logic/fes_top.sv ====
// Fatal-error supervisor with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module fes_top
  import fes_pkg::*;
#(
  parameter int unsigned PWR_LOSS_CYC = PWR_LOSS_MS_CYC,
  parameter int unsigned MS_CYC = CYC_PER_MS
)(
  input wire logic clk_sys, // 40 MHz
  input wire logic rst_n, // Restart / power-up, sync, low
  input wire fes_fault_t fault_i, // Detector levels
  input wire fes_ffi_t ffi_i, // Fatal-failure instruction strobe and scan start
  input wire logic comm_err_p, // Peripheral port comm error level
  input wire logic comm_err_s, // Serial port comm error level
  input wire logic comm_act_p, // Peripheral port traffic
  input wire logic comm_act_s, // Serial port traffic
  input wire logic [7:0] out_img, // Output image from the CPU
  output logic [7:0] out_drv, // Outputs to I/O units
  output logic run_out, // Run output
  output logic pwr_ind, // Power indicator
  output logic alarm_error_indicator, // Alarm/error indicator
  output logic peripheral_port_indicator, // Peripheral port indicator
  output logic serial_port_indicator, // Serial port indicator
  output logic port_init_p, // Peripheral port reinit pulse
  output logic port_init_s, // Serial port reinit pulse
  output logic irq, // Interrupt level
  input wire logic [7:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI
  output logic s_axi_awready, // AXI
  input wire logic [31:0] s_axi_wdata, // AXI
  input wire logic [3:0] s_axi_wstrb, // AXI
  input wire logic s_axi_wvalid, // AXI
  output logic s_axi_wready, // AXI
  output logic [1:0] s_axi_bresp, // AXI
  output logic s_axi_bvalid, // AXI
  input wire logic s_axi_bready, // AXI
  input wire logic [7:0] s_axi_araddr, // AXI
  input wire logic s_axi_arvalid, // AXI
  output logic s_axi_arready, // AXI
  output logic [31:0] s_axi_rdata, // AXI
  output logic [1:0] s_axi_rresp, // AXI
  output logic s_axi_rvalid, // AXI
  input wire logic s_axi_rready // AXI
);
  initial
  begin
    if (PWR_LOSS_CYC < 1) $error("PWR_LOSS_CYC must be at least 1");
    if (PWR_LOSS_CYC >= (1 << 24)) $error("PWR_LOSS_CYC must fit the 24-bit loss counter");
    if (MS_CYC < 2) $error("MS_CYC must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and cycle timer
  localparam int unsigned MSW = $clog2(MS_CYC);
  logic [MSW-1:0] ms_q;
  logic ms_tick;
  logic [15:0] cyc_ms_q;
  logic [15:0] wdt_lim_q;
  logic [23:0] pwr_cnt_q;
  fes_state_t st_q;
  fes_kind_t kind_q;
  logic [7:0] code_q;
  logic [4:0] memflg_q;
  logic [IRQ_W-1:0] ist_q, imsk_q;

  assign ms_tick = (ms_q == MSW'(MS_CYC - 1));

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) ms_q <= '0;
    else if (ms_tick || ffi_i.cycle_start) ms_q <= '0;
    else ms_q <= ms_q + 1'b1;
  end

  // Cycle time in ms, restarted at every scan start
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) cyc_ms_q <= '0;
    else if (ffi_i.cycle_start) cyc_ms_q <= '0;
    else if (ms_tick && cyc_ms_q != 16'hFFFF) cyc_ms_q <= cyc_ms_q + 1'b1;
  end

  // Supply loss must persist the full time; glitches do not count
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !fault_i.pwr_fail) pwr_cnt_q <= '0;
    else if (pwr_cnt_q != 24'(PWR_LOSS_CYC)) pwr_cnt_q <= pwr_cnt_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fatal detection, first error wins and is latched
  wire pwr_hit = (pwr_cnt_q == 24'(PWR_LOSS_CYC));
  wire wdt_hit = (cyc_ms_q >= wdt_lim_q);
  wire [4:0] mem_v = {fault_i.mem_boot, fault_i.mem_cass, fault_i.mem_exp,
                      fault_i.mem_prog, fault_i.mem_setup};
  wire mem_hit = |mem_v;
  wire bus_ok_rack = (fault_i.bus_rack <= RACK_MAX);
  wire bus_hit = fault_i.bus_fault && bus_ok_rack;
  wire ffi_ok = ffi_i.exec && ffi_i.num >= FFI_MIN && ffi_i.num <= FFI_MAX;
  wire ffi_slow = (cyc_ms_q >= 16'(FFI_LO_MS)) && (cyc_ms_q <= 16'(WDT_DEF_MS));
  wire ffi_hit = ffi_ok || (ffi_i.exec && ffi_slow);

  fes_kind_t kind_d;
  logic [7:0] code_d;
  // Power loss outranks all: no indicator can light without supply unless another fault latched first
  assign kind_d = pwr_hit ? K_PWR :
                  wdt_hit ? K_WDT :
                  mem_hit ? K_MEM :
                  fault_i.no_end ? K_NOEND :
                  bus_hit ? K_BUS :
                  fault_i.unit_dup ? K_UNIT :
                  fault_i.io_tbl ? K_IOTBL :
                  (ffi_i.exec && ffi_slow) ? K_SYSF :
                  ffi_hit ? K_FFI : K_NONE;
  always_comb
  begin
    unique case (kind_d)
      K_MEM: code_d = C_MEM;
      K_NOEND: code_d = C_NOEND;
      K_BUS: code_d = C_BUS0 | {6'h00, fault_i.bus_rack};
      K_UNIT: code_d = C_UNIT;
      K_IOTBL: code_d = C_IOTBL;
      K_SYSF: code_d = C_SYSF;
      K_FFI: code_d = ffi_i.num;
      default: code_d = C_NONE;
    endcase
  end

  wire new_fatal = (st_q == S_RUN) && (kind_d != K_NONE);
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_q <= S_RUN;
      kind_q <= K_NONE;
      code_q <= C_NONE;
      memflg_q <= '0;
    end
    else if (new_fatal)
    begin
      st_q <= S_HALT;
      kind_q <= kind_d;
      code_q <= code_d;
      memflg_q <= (kind_d == K_MEM) ? mem_v : 5'h00;
    end
  end
  wire halted = (st_q == S_HALT);

  ////////////////////////////////////////////////////////////////////////////
  // Port reset pulses and indicators
  logic rst_p_req, rst_s_req;
  logic [1:0] port_q;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      port_init_p <= 1'b0;
      port_init_s <= 1'b0;
    end
    else
    begin
      port_init_p <= rst_p_req;
      port_init_s <= rst_s_req;
    end
  end

  // Sticky error per port, set on the error's onset: the far side drops its error level
  // only after the reinit pulse, so a level-set flag could never be cleared
  logic [1:0] cerr_q;
  wire [1:0] cerr = {comm_err_s, comm_err_p};
  wire [1:0] cerr_rise = cerr & ~cerr_q;
  wire [1:0] port_clr = {rst_s_req, rst_p_req};
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cerr_q <= '0;
      port_q <= '0;
    end
    else
    begin
      cerr_q <= cerr;
      port_q <= cerr_rise | (port_q & ~port_clr);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      out_drv <= '0;
      run_out <= 1'b0;
      pwr_ind <= 1'b0;
      alarm_error_indicator <= 1'b0;
      peripheral_port_indicator <= 1'b0;
      serial_port_indicator <= 1'b0;
    end
    else
    begin
      out_drv <= (halted || new_fatal) ? 8'h00 : out_img;
      run_out <= !(halted || new_fatal);
      pwr_ind <= !((halted && kind_q == K_PWR) || (new_fatal && kind_d == K_PWR));
      alarm_error_indicator <= (halted && kind_q != K_PWR) ||
                               (new_fatal && kind_d != K_PWR);
      peripheral_port_indicator <= comm_act_p && !port_q[0] && !comm_err_p
                                   && !(halted && kind_q == K_PWR);
      serial_port_indicator <= comm_act_s && !port_q[1] && !comm_err_s
                               && !(halted && kind_q == K_PWR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order
  logic aw_have_q, w_have_q;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  // Ready flags are flops that track !held && !bvalid
  wire do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
  wire wr_st = do_wr && aw_q == A_IRQ_ST && ws_q[0];
  wire wr_msk = do_wr && aw_q == A_IRQ_MSK && ws_q[0];
  wire wr_wdt = do_wr && aw_q == A_WDTCFG && ws_q[0];
  wire wr_port = do_wr && aw_q == A_PORT && ws_q[0];
  wire wr_ok = aw_q == A_IRQ_ST || aw_q == A_IRQ_MSK || aw_q == A_WDTCFG
               || aw_q == A_PORT || aw_q == A_CTRL || aw_q == A_STATUS
               || aw_q == A_CODE || aw_q == A_MEMFLG;
  assign rst_p_req = wr_port && w_q[0];
  assign rst_s_req = wr_port && w_q[1];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= '0;
      w_q <= '0;
      ws_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OK : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Watchdog limit; zero is refused so the CPU cannot be halted at once
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) wdt_lim_q <= WDT_RST[15:0];
    else if (wr_wdt && w_q[15:0] != 16'h0000) wdt_lim_q <= w_q[15:0];
  end

  // Interrupts: set beats write-one-to-clear
  logic [IRQ_W-1:0] iev;
  assign iev[IB_FATAL] = new_fatal;
  assign iev[IB_COMM_P] = comm_err_p && !port_q[0];
  assign iev[IB_COMM_S] = comm_err_s && !port_q[1];
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ist_q <= '0;
      imsk_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      ist_q <= (ist_q & ~(wr_st ? w_q[IRQ_W-1:0] : '0)) | iev;
      if (wr_msk) imsk_q <= w_q[IRQ_W-1:0];
      irq <= |(ist_q & imsk_q);
    end
  end

  // Read channel
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb
  begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      A_STATUS: rd_mux = {21'h0, kind_q, halted, run_out};
      A_CODE: rd_mux = {24'h0, code_q};
      A_MEMFLG: rd_mux = {27'h0, memflg_q};
      A_WDTCFG: rd_mux = {16'h0, wdt_lim_q};
      A_IRQ_ST: rd_mux = {29'h0, ist_q};
      A_IRQ_MSK: rd_mux = {29'h0, imsk_q};
      A_PORT: rd_mux = {30'h0, port_q};
      A_CTRL: rd_mux = {16'h0, cyc_ms_q};
      default:
      begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end
  // Registered arready mirrors !rvalid: one read at a time
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? RESP_OK : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== logic/fes_pkg.sv ====
// Constants, types and register map of the fatal-error supervisor
package fes_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned PWR_LOSS_MS = 10;
  localparam int unsigned WDT_DEF_MS = 130;
  localparam int unsigned FFI_LO_MS = 120;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned PWR_LOSS_MS_CYC = PWR_LOSS_MS * CYC_PER_MS;
  // Register byte addresses
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_CODE = 8'h04;
  localparam logic [7:0] A_MEMFLG = 8'h08;
  localparam logic [7:0] A_WDTCFG = 8'h0C;
  localparam logic [7:0] A_IRQ_ST = 8'h10;
  localparam logic [7:0] A_IRQ_MSK = 8'h14;
  localparam logic [7:0] A_PORT = 8'h18;
  localparam logic [7:0] A_CTRL = 8'h1C;
  // Failure codes, limits, reset value and bus responses
  localparam logic [7:0] C_NONE = 8'h00;
  localparam logic [7:0] C_MEM = 8'hF1;
  localparam logic [7:0] C_NOEND = 8'hF0;
  localparam logic [7:0] C_BUS0 = 8'hC0;
  localparam logic [7:0] C_UNIT = 8'hE1;
  localparam logic [7:0] C_IOTBL = 8'hE0;
  localparam logic [7:0] C_SYSF = 8'h9F;
  localparam logic [7:0] FFI_MIN = 8'h01;
  localparam logic [7:0] FFI_MAX = 8'h99;
  localparam logic [1:0] RACK_MAX = 2'h2;
  localparam logic [31:0] WDT_RST = 32'h0000_0082;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Interrupt status bit positions
  localparam int unsigned IB_FATAL = 0;
  localparam int unsigned IB_COMM_P = 1;
  localparam int unsigned IB_COMM_S = 2;
  localparam int unsigned IRQ_W = 3;

  typedef enum logic [8:0] {
    K_NONE = 9'h000, K_PWR = 9'h001, K_WDT = 9'h002, K_MEM = 9'h004,
    K_NOEND = 9'h008, K_BUS = 9'h010, K_UNIT = 9'h020, K_IOTBL = 9'h040,
    K_FFI = 9'h080, K_SYSF = 9'h100
  } fes_kind_t;

  typedef enum logic [1:0] {
    S_RUN = 2'b01, S_HALT = 2'b10
  } fes_state_t;

  typedef struct packed {
    logic pwr_fail;
    logic mem_setup;
    logic mem_prog;
    logic mem_exp;
    logic mem_cass;
    logic mem_boot;
    logic no_end;
    logic bus_fault;
    logic [1:0] bus_rack;
    logic unit_dup;
    logic io_tbl;
  } fes_fault_t;

  typedef struct packed {
    logic exec;
    logic [7:0] num;
    logic cycle_start;
  } fes_ffi_t;
endpackage

// ==== tb/fes_port_model.sv ====
// Behavioural model of the two communication ports facing the supervisor
`timescale 1ns/1ps
`default_nettype none
module fes_port_model (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Restart
  input wire logic [1:0] break_req, // Bench breaks a link, bit0 peripheral
  input wire logic [1:0] init_req, // Reinit pulses from the device
  output logic [1:0] err, // Error levels
  output logic [1:0] act // Traffic levels
);
  // Traffic keeps flowing on a broken link, so a dark lamp is due to the error alone
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      err <= 2'h0;
      act <= 2'h0;
    end
    else
    begin
      err <= (err | break_req) & ~init_req;
      act <= 2'h3;
    end
  end
endmodule
`default_nettype wire

// ==== tb/fes_assertions.sv ====
// Port-level checks of the fatal-error supervisor
`timescale 1ns/1ps
`default_nettype none
module fes_assertions
  import fes_pkg::*;
#(
  parameter int unsigned PWR_LOSS_CYC = PWR_LOSS_MS_CYC
)(
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Restart
  input wire fes_fault_t fault_i, // Faults
  input wire fes_ffi_t ffi_i, // Instruction
  input wire logic comm_err_p, // Error
  input wire logic comm_err_s, // Error
  input wire logic [7:0] out_drv, // Outputs
  input wire logic run_out, // Run
  input wire logic pwr_ind, // Lamp
  input wire logic alarm_error_indicator, // Lamp
  input wire logic peripheral_port_indicator, // Lamp
  input wire logic serial_port_indicator, // Lamp
  input wire logic port_init_p, // Reinit
  input wire logic [7:0] s_axi_awaddr, // Bus
  input wire logic s_axi_awvalid, // Bus
  input wire logic s_axi_awready, // Bus
  input wire logic [31:0] s_axi_wdata, // Bus
  input wire logic s_axi_wvalid, // Bus
  input wire logic s_axi_wready // Bus
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic nf;
  logic seen_q;
  int unsigned pwr_q;
  // Racks beyond the last one are not a bus fault
  assign nf = |{fault_i.mem_setup, fault_i.mem_prog, fault_i.mem_exp, fault_i.mem_cass,
    fault_i.mem_boot, fault_i.no_end, fault_i.unit_dup, fault_i.io_tbl,
    fault_i.bus_fault && fault_i.bus_rack <= RACK_MAX};
  // Another fault seen first keeps the lamps lit, so the dark check steps aside
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      seen_q <= 1'b0;
      pwr_q <= 0;
    end
    else
    begin
      seen_q <= seen_q | nf | ffi_i.exec;
      pwr_q <= fault_i.pwr_fail ? pwr_q + 1 : 0;
    end
  end
  sequence s_halt;
    !run_out && out_drv == 8'h00;
  endsequence
  sequence s_port_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr == A_PORT && s_axi_wdata[0];
  endsequence
  a_fault_halts: assert property (run_out && nf |-> ##[1:2] s_halt)
    else $error("fault did not halt");
  a_fault_lamps: assert property (run_out && nf |-> ##[1:2]
    (pwr_ind && alarm_error_indicator)) else $error("fault lamps not lit");
  a_halt_holds: assert property ($fell(run_out) |=> s_halt [*8])
    else $error("halt released");
  a_power_dark: assert property (pwr_q > PWR_LOSS_CYC + 2 && !seen_q |-> !(pwr_ind
    | alarm_error_indicator | peripheral_port_indicator | serial_port_indicator | run_out))
    else $error("power loss not dark");
  a_periph_dark: assert property (comm_err_p |=> !peripheral_port_indicator)
    else $error("peripheral lamp lit on error");
  a_serial_dark: assert property (comm_err_s |=> !serial_port_indicator)
    else $error("serial lamp lit on error");
  a_port_reinit: assert property (s_port_wr |-> ##[1:2] port_init_p)
    else $error("no reinit pulse");
  a_init_short: assert property (port_init_p |=> !port_init_p)
    else $error("reinit pulse too long");
endmodule
bind fes_top fes_assertions #(.PWR_LOSS_CYC(PWR_LOSS_CYC)) u_chk (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench of the fatal-error supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fes_pkg::*;
  localparam int unsigned PL = 10;
  localparam int unsigned MSC = 100;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  fes_fault_t fault_i = '0;
  fes_ffi_t ffi_i = '0;
  logic [1:0] brk = 2'h0;
  logic [1:0] cerr, cact;
  logic [7:0] out_drv;
  logic run_out, pwr_ind, alarm_error_indicator, peripheral_port_indicator;
  logic serial_port_indicator, port_init_p, port_init_s, irq;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [3:0] lamps;
  int miscompares = 0;
  int total_checks = 0;
  logic [11:0] ftab [11] = '{12'h400, 12'h200, 12'h100, 12'h080, 12'h040, 12'h020, 12'h010,
    12'h014, 12'h018, 12'h002, 12'h001};
  logic [7:0] ctab [11] = '{C_MEM, C_MEM, C_MEM, C_MEM, C_MEM, C_NOEND, C_BUS0, 8'hC1, 8'hC2,
    C_UNIT, C_IOTBL};
  logic [7:0] ntab [3] = '{8'h01, 8'h42, 8'h99};
  assign lamps = {pwr_ind, alarm_error_indicator, serial_port_indicator,
    peripheral_port_indicator};
  always #12.5 clk_sys = ~clk_sys;
  fes_top #(.PWR_LOSS_CYC(PL), .MS_CYC(MSC)) dut (.*, .comm_err_p(cerr[0]),
    .comm_err_s(cerr[1]), .comm_act_p(cact[0]), .comm_act_s(cact[1]), .out_img(8'h5A),
    .s_axi_wstrb(4'hF));
  fes_port_model u_ports (.clk_sys, .rst_n, .break_req(brk),
    .init_req({port_init_s, port_init_p}), .err(cerr), .act(cact));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tmo(input logic ok);
    if (!ok)
    begin
      chk("wait", 0, 1);
      summarize();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic rst();
    rst_n <= 1'b0;
    fault_i <= '0;
    ffi_i <= '0;
    tick(12);
    rst_n <= 1'b1;
    tick(3);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clk_sys);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    tmo(n < 200);
    tick(1);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clk_sys);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    tmo(n < 200);
    tick(1);
  endtask
  task automatic ffi_run(input logic [7:0] num);
    ffi_i <= '{1'b1, num, 1'b0};
    tick(1);
    ffi_i <= '0;
    tick(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int i;
    rst();
    chk("out_drv", out_drv, 8'h5A);
    axi_rd(A_WDTCFG);
    chk("wdt", rd, WDT_RST);
    axi_rd(8'h40);
    chk("resp", rsp, RESP_SLVERR);
    $display("test idle done");
    for (i = 0; i < 11; i++)
    begin
      rst();
      fault_i <= ftab[i];
      tick(3);
      fault_i <= '0;
      tick(3);
      chk("out_drv", out_drv, 0);
      chk("run_out", run_out, 0);
      chk("lamps", lamps[3:2], 2'b11);
      axi_rd(A_CODE);
      chk("code", rd[7:0], ctab[i]);
      axi_rd(A_MEMFLG);
      chk("memflg", rd[4:0], (i < 5) ? 5'h1 << i : 5'h0);
    end
    $display("test faults done");
    rst();
    fault_i <= 12'h800;
    tick(PL - 4);
    fault_i <= '0;
    tick(3);
    chk("run_out", run_out, 1);
    fault_i <= 12'h800;
    tick(PL + 4);
    chk("lamps", lamps, 4'h0);
    chk("out_drv", out_drv, 0);
    fault_i <= '0;
    axi_rd(A_CODE);
    chk("code", rd[7:0], C_NONE);
    $display("test power done");
    for (i = 0; i < 3; i++)
    begin
      rst();
      ffi_run(8'hA0);
      chk("run_out", run_out, 1);
      ffi_run(ntab[i]);
      chk("run_out", run_out, 0);
      chk("lamps", lamps[3:2], 2'b11);
      axi_rd(A_CODE);
      chk("code", rd[7:0], ntab[i]);
    end
    $display("test instruction done");
    rst();
    ffi_i <= '{1'b0, 8'h00, 1'b1};
    tick(1);
    ffi_i <= '0;
    tick(121 * MSC);
    ffi_run(ntab[1]);
    chk("run_out", run_out, 0);
    chk("lamps", lamps[3:2], 2'b11);
    axi_rd(A_CODE);
    chk("code", rd[7:0], C_SYSF);
    $display("test slow cycle done");
    rst();
    for (i = 0; i < 2; i++)
    begin
      axi_wr(A_IRQ_MSK, 32'h0);
      brk[i] <= 1'b1;
      tick(1);
      brk[i] <= 1'b0;
      tick(3);
      chk("port lamp", lamps[i], 0);
      chk("irq", irq, 0);
      axi_wr(A_IRQ_MSK, 32'h6);
      tick(2);
      chk("irq", irq, 1);
      axi_wr(A_PORT, 32'h1 << i);
      tick(3);
      chk("port lamp", lamps[i], 1);
      axi_wr(A_IRQ_ST, 32'h2 << i);
      tick(2);
      chk("irq", irq, 0);
    end
    $display("test ports done");
    rst();
    axi_wr(A_WDTCFG, 32'h0);
    chk("bresp", rsp, RESP_OK);
    axi_rd(A_WDTCFG);
    chk("wdt", rd, WDT_RST);
    axi_wr(A_WDTCFG, 32'h1);
    ffi_i <= '{1'b0, 8'h00, 1'b1};
    tick(1);
    ffi_i <= '0;
    for (i = 0; i < 2000 && run_out; i++)
      tick(1);
    tmo(i < 2000);
    tick(2);
    chk("lamps", lamps[3:2], 2'b11);
    axi_rd(A_CODE);
    chk("code", rd[7:0], C_NONE);
    $display("test watchdog done");
    summarize();
  end
endmodule
`default_nettype wire
